// ===== hdl/dbg_pkg.sv
// package for the debug trace readout and comparator a extension block
// assumes a 100 MHz single clock and a classic wishbone register bus
package dbg_pkg;

	// register indices; byte address is four times the index
	localparam logic [5:0] IDX_CMP_A_HIGH   = 6'h00;
	localparam logic [5:0] IDX_CMP_A_LOW    = 6'h01;
	localparam logic [5:0] IDX_TRACE_HIGH   = 6'h06;
	localparam logic [5:0] IDX_TRACE_LOW    = 6'h07;
	localparam logic [5:0] IDX_CMP_A_EXT    = 6'h08;
	localparam logic [5:0] IDX_TRACE_CTRL   = 6'h0C;
	localparam logic [5:0] IDX_TRACE_STATUS = 6'h0D;

	// comparator a extension fields
	localparam int EXT_DIR_EN_BIT  = 7;
	localparam int EXT_DIR_VAL_BIT = 6;
	localparam int EXT_PAGE_Q_BIT  = 5;
	localparam int EXT_BIT16_BIT   = 0;

	// trace control fields
	localparam int CTRL_DBG_EN_BIT  = 7;
	localparam int CTRL_BEGIN_BIT   = 6;
	localparam int CTRL_CAPTURE_BIT = 1;
	localparam int CTRL_EVENT_BIT   = 0;

	// trace status fields
	localparam int STAT_MATCH_BIT = 7;

	localparam logic [7:0]  RESET_BYTE = 8'h00;
	localparam logic [31:0] RESET_WORD = 32'h0000_0000;

	typedef struct packed {
		logic        dir_en;
		logic        dir_val;
		logic        page_q;
		logic        bit16;
		logic [15:0] addr;
	} cmp_a_cfg_t;

	typedef struct packed {
		logic        valid;
		logic [15:0] addr;
		logic        rd;
		logic        ppage_sel;
		logic [2:0]  ppage;
		logic        lin_sel;
		logic [16:0] lin_addr;
	} core_bus_t;

	typedef struct packed {
		logic dbg_en;
		logic begin_trig;
		logic capture;
		logic event_only;
	} trace_ctrl_t;

endpackage

// ===== hdl/trace_fifo.sv
// trace buffer: flip-flop fifo with valid/ready on both sides
// assumes clr_i is a synchronous flush that also serves as reset
`timescale 1ns/1ps
`default_nettype none
module trace_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	input  wire logic                         clk_i,
	input  wire logic                         clr_i,
	input  wire logic                         in_valid_i,
	input  wire logic [WIDTH-1:0]             in_data_i,
	output logic                              in_ready_o,
	output logic                              out_valid_o,
	output logic [WIDTH-1:0]                  out_data_o,
	input  wire logic                         out_ready_i,
	output logic [$clog2(DEPTH+1)-1:0]        count_o
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH+1);

	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_chk
		$error("trace_fifo: depth must be a power of two of at least 2");
	end

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wp;
		logic [AW-1:0]               rp;
		logic [CW-1:0]               cnt;
		logic                        full;
	} fifo_state_t;

	fifo_state_t st_r;
	fifo_state_t st_nxt;
	logic        push;
	logic        pop;

	assign push        = in_valid_i && !st_r.full;
	assign pop         = out_ready_i && (st_r.cnt != '0);
	assign in_ready_o  = !st_r.full;
	assign out_valid_o = (st_r.cnt != '0);
	assign out_data_o  = st_r.mem[st_r.rp];
	assign count_o     = st_r.cnt;

	always_comb begin
		st_nxt = st_r;
		if (push) begin
			st_nxt.mem[st_r.wp] = in_data_i;
			st_nxt.wp = st_r.wp + AW'(1);
		end
		if (pop) begin
			st_nxt.rp = st_r.rp + AW'(1);
		end
		if (push && !pop) begin
			st_nxt.cnt = st_r.cnt + CW'(1);
		end else if (pop && !push) begin
			st_nxt.cnt = st_r.cnt - CW'(1);
		end
		st_nxt.full = (st_nxt.cnt == CW'(DEPTH));
	end

	always_ff @(posedge clk_i) begin
		if (clr_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
endmodule
`default_nettype wire

// ===== hdl/cmp_a_match.sv
// comparator a: 17-bit core address match with direction and page qualifiers
// assumes the core bus fields are synchronous to clk_i
`timescale 1ns/1ps
`default_nettype none
module cmp_a_match
	import dbg_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire cmp_a_cfg_t cfg_i,
	input  wire core_bus_t  bus_i,
	output logic            match_o
);
	typedef struct packed {
		logic match;
	} cmp_state_t;

	cmp_state_t  st_r;
	cmp_state_t  st_nxt;
	logic [16:0] core_addr;
	logic [16:0] expect_addr;

	always_comb begin
		st_nxt = st_r;
		// paged access builds the address from page and low 14 bits
		if (bus_i.ppage_sel) begin
			core_addr = {bus_i.ppage, bus_i.addr[13:0]};
		end else if (bus_i.lin_sel) begin
			core_addr = bus_i.lin_addr;
		end else begin
			core_addr = {1'b0, bus_i.addr};
		end
		expect_addr = {cfg_i.bit16, cfg_i.addr};
		st_nxt.match = bus_i.valid
			&& (core_addr == expect_addr)
			&& (bus_i.ppage_sel == cfg_i.page_q)
			&& (!cfg_i.dir_en || (bus_i.rd == cfg_i.dir_val));
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign match_o = st_r.match;
endmodule
`default_nettype wire

// ===== hdl/debug_trace_unit.sv
// debug trace buffer readout and comparator a extension, wishbone slave
// assumes synchronous inputs on clk_i; rst_i is power-on reset
//
// Register access over Wishbone is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module debug_trace_unit
	import dbg_pkg::*;
#(
	parameter int TRACE_WIDTH = 16,
	parameter int TRACE_DEPTH = 8
) (
	input  wire logic                    clk_i,
	input  wire logic                    rst_i,
	input  wire logic                    trace_rst_i,
	input  wire logic                    wb_cyc_i,
	input  wire logic                    wb_stb_i,
	input  wire logic                    wb_we_i,
	input  wire logic [7:0]              wb_adr_i,
	input  wire logic [3:0]              wb_sel_i,
	input  wire logic [31:0]             wb_dat_i,
	output logic      [31:0]             wb_dat_o,
	output logic                         wb_ack_o,
	input  wire core_bus_t               core_bus_i,
	input  wire logic                    trace_valid_i,
	input  wire logic [TRACE_WIDTH-1:0]  trace_data_i,
	output logic                         trace_ready_o,
	output logic                         match_o
);
	// ************************************************************
	// elaboration checks
	// ************************************************************
	if (TRACE_WIDTH != 16) begin : g_chk
		$error("debug_trace_unit: trace words are 16 bits wide");
	end
	// the status count field must stay clear of the match flag in bit 7
	if (TRACE_DEPTH < 2 || TRACE_DEPTH > 64) begin : g_chk_depth
		$error("debug_trace_unit: trace depth must lie between 2 and 64");
	end

	localparam int CW = $clog2(TRACE_DEPTH+1);

	// ************************************************************
	// state
	// ************************************************************
	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
		cmp_a_cfg_t  cmp;
		trace_ctrl_t ctrl;
		logic        ready;
	} unit_state_t;

	unit_state_t            st_r;
	unit_state_t            st_nxt;
	logic                   keep;
	logic                   flush;
	logic                   req;
	logic                   wr_now;
	logic                   rd_pop;
	logic [5:0]             idx;
	logic                   fifo_in_ready;
	logic                   fifo_out_valid;
	logic [TRACE_WIDTH-1:0] fifo_head;
	logic [CW-1:0]          fifo_count;
	logic                   cmp_clr;
	logic                   cmp_match;
	logic [7:0]             rd_byte;
	logic                   push_now;
	logic                   last_slot;
	logic                   will_fill;

	function automatic logic hit(input logic [5:0] a, input logic [5:0] r);
		return a == r;
	endfunction

	function automatic logic [7:0] ext_byte(input cmp_a_cfg_t c);
		logic [7:0] b;
		b = RESET_BYTE;
		b[EXT_DIR_EN_BIT]  = c.dir_en;
		b[EXT_DIR_VAL_BIT] = c.dir_val;
		b[EXT_PAGE_Q_BIT]  = c.page_q;
		b[EXT_BIT16_BIT]   = c.bit16;
		return b;
	endfunction

	// ************************************************************
	// reset policy
	// ************************************************************
	// a trace-ending reset keeps buffer and comparator state
	assign keep    = st_r.ctrl.dbg_en && !st_r.ctrl.begin_trig;
	assign flush   = rst_i || (trace_rst_i && !keep);
	assign cmp_clr = flush;

	// ************************************************************
	// trace input flow control
	// ************************************************************
	// ready is registered, so it must fall one word ahead of full
	assign push_now  = trace_valid_i && st_r.ready;
	assign last_slot = (fifo_count == CW'(TRACE_DEPTH - 1));
	assign will_fill = push_now && last_slot && !rd_pop;

	// ************************************************************
	// bus decode
	// ************************************************************
	assign idx    = wb_adr_i[7:2];
	assign req    = wb_cyc_i && wb_stb_i;
	// writes and pops act on the edge where the master sees ack
	assign wr_now = req && st_r.ack && wb_we_i && wb_sel_i[0];
	assign rd_pop = req && st_r.ack && !wb_we_i && hit(idx, IDX_TRACE_LOW)
		&& fifo_out_valid;

	// ************************************************************
	// register read
	// ************************************************************
	always_comb begin
		rd_byte = RESET_BYTE;
		unique case (1'b1)
			hit(idx, IDX_CMP_A_HIGH): begin
				rd_byte = st_r.cmp.addr[15:8];
			end
			hit(idx, IDX_CMP_A_LOW): begin
				rd_byte = st_r.cmp.addr[7:0];
			end
			hit(idx, IDX_TRACE_HIGH): begin
				if (fifo_out_valid && !st_r.ctrl.event_only) begin
					rd_byte = fifo_head[15:8];
				end else begin
					rd_byte = RESET_BYTE;
				end
			end
			hit(idx, IDX_TRACE_LOW): begin
				if (fifo_out_valid) begin
					rd_byte = fifo_head[7:0];
				end
			end
			hit(idx, IDX_CMP_A_EXT): begin
				rd_byte = ext_byte(st_r.cmp);
			end
			hit(idx, IDX_TRACE_CTRL): begin
				rd_byte[CTRL_DBG_EN_BIT]  = st_r.ctrl.dbg_en;
				rd_byte[CTRL_BEGIN_BIT]   = st_r.ctrl.begin_trig;
				rd_byte[CTRL_CAPTURE_BIT] = st_r.ctrl.capture;
				rd_byte[CTRL_EVENT_BIT]   = st_r.ctrl.event_only;
			end
			hit(idx, IDX_TRACE_STATUS): begin
				rd_byte[CW-1:0]         = fifo_count;
				rd_byte[STAT_MATCH_BIT] = cmp_match;
			end
			default: begin
				rd_byte = RESET_BYTE;
			end
		endcase
	end

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		st_nxt = st_r;
		st_nxt.ack = req && !st_r.ack;
		if (req && !st_r.ack && !wb_we_i) begin
			st_nxt.dat = {24'h00_0000, rd_byte};
		end
		if (wr_now) begin
			unique case (1'b1)
				hit(idx, IDX_CMP_A_HIGH): begin
					st_nxt.cmp.addr[15:8] = wb_dat_i[7:0];
				end
				hit(idx, IDX_CMP_A_LOW): begin
					st_nxt.cmp.addr[7:0] = wb_dat_i[7:0];
				end
				hit(idx, IDX_CMP_A_EXT): begin
					st_nxt.cmp.dir_en  = wb_dat_i[EXT_DIR_EN_BIT];
					st_nxt.cmp.dir_val = wb_dat_i[EXT_DIR_VAL_BIT];
					st_nxt.cmp.page_q  = wb_dat_i[EXT_PAGE_Q_BIT];
					st_nxt.cmp.bit16   = wb_dat_i[EXT_BIT16_BIT];
				end
				hit(idx, IDX_TRACE_CTRL): begin
					st_nxt.ctrl.dbg_en     = wb_dat_i[CTRL_DBG_EN_BIT];
					st_nxt.ctrl.begin_trig = wb_dat_i[CTRL_BEGIN_BIT];
					st_nxt.ctrl.capture    = wb_dat_i[CTRL_CAPTURE_BIT];
					st_nxt.ctrl.event_only = wb_dat_i[CTRL_EVENT_BIT];
				end
				default: begin
					st_nxt.cmp = st_r.cmp;
				end
			endcase
		end
		if (flush) begin
			st_nxt.cmp = '0;
		end
		// ready reflects fill state for the next cycle's offer
		st_nxt.ready = st_r.ctrl.capture && fifo_in_ready && !will_fill;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ************************************************************
	// buffer and comparator
	// ************************************************************
	trace_fifo #(
		.WIDTH (TRACE_WIDTH),
		.DEPTH (TRACE_DEPTH)
	) u_fifo (
		.clk_i       (clk_i),
		.clr_i       (flush),
		.in_valid_i  (push_now),
		.in_data_i   (trace_data_i),
		.in_ready_o  (fifo_in_ready),
		.out_valid_o (fifo_out_valid),
		.out_data_o  (fifo_head),
		.out_ready_i (rd_pop),
		.count_o     (fifo_count)
	);

	cmp_a_match u_cmp (
		.clk_i   (clk_i),
		.rst_i   (cmp_clr),
		.cfg_i   (st_r.cmp),
		.bus_i   (core_bus_i),
		.match_o (cmp_match)
	);

	assign wb_ack_o      = st_r.ack;
	assign wb_dat_o      = st_r.dat;
	assign trace_ready_o = st_r.ready;
	assign match_o       = cmp_match;
endmodule
`default_nettype wire

// ===== sim/debug_trace_unit_monitor.sv
// checker for the debug trace unit bus, reset and match outputs
// assumes it is bound to debug_trace_unit and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module debug_trace_unit_monitor
	import dbg_pkg::*;
#(
	parameter int TRACE_WIDTH = 16,
	parameter int TRACE_DEPTH = 8
) (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire core_bus_t   core_bus_i,
	input wire logic        trace_valid_i,
	input wire logic        trace_ready_o,
	input wire logic        match_o
);
	// ****************
	// assertions
	// ****************
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic req;
	logic bus_v;
	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign bus_v = core_bus_i.valid;
	ack_latency_a: assert property (req |=> wb_ack_o) else $error("ack late");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
	ack_cause_a: assert property (wb_ack_o |-> $past(req)) else $error("stray ack");
	upper_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
		else $error("upper read bits set");
	ext_reserved_a: assert property (wb_ack_o && !wb_we_i
		&& wb_adr_i[7:2] == IDX_CMP_A_EXT |-> wb_dat_o[4:1] == 4'h0) else $error("reserved set");
	unmapped_zero_a: assert property (wb_ack_o && !wb_we_i
		&& wb_adr_i[7:6] != 2'h0 |-> wb_dat_o == 32'h0) else $error("unmapped not zero");
	reset_clear_a: assert property (disable iff (1'b0) rst_i |=> !wb_ack_o && !match_o
		&& !trace_ready_o && wb_dat_o == 32'h0) else $error("reset not clear");
	match_cause_a: assert property (match_o |-> $past(bus_v)) else $error("stray match");
	cover property (match_o);
	cover property (wb_ack_o && wb_adr_i[7:2] == IDX_TRACE_LOW);
	cover property (trace_valid_i && trace_ready_o);
endmodule
bind debug_trace_unit debug_trace_unit_monitor #(.TRACE_WIDTH(TRACE_WIDTH),
	.TRACE_DEPTH(TRACE_DEPTH)) mon (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .core_bus_i(core_bus_i), .trace_valid_i(trace_valid_i),
	.trace_ready_o(trace_ready_o), .match_o(match_o));
`default_nettype wire

// ===== sim/core_bus_model.sv
// core bus partner: issues one bus cycle per go pulse
// assumes go_i and req_i change just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module core_bus_model
	import dbg_pkg::*;
(
	input  wire logic      clk_i,
	input  wire logic      rst_i,
	input  wire logic      go_i,
	input  wire core_bus_t req_i,
	output core_bus_t      bus_o
);
	// ****************
	// bus cycle driver
	// ****************
	// idle fields flip every cycle so stale values never match by chance
	always_ff @(posedge clk_i) begin
		if (rst_i)
			bus_o <= '0;
		else if (go_i)
			bus_o <= req_i;
		else
			bus_o <= {1'b0, ~bus_o[38:0]};
	end
endmodule
`default_nettype wire

// ===== sim/test_debug_trace_unit.sv
// self-checking bench for the debug trace unit
// assumes dbg_pkg, the design, the monitor and core_bus_model are compiled first
`timescale 1ns/1ps
`default_nettype none
module test_debug_trace_unit
	import dbg_pkg::*;
;
	logic        clk_i = 1'b0, rst_i = 1'b1, trst = 1'b0, go = 1'b0, tv = 1'b0;
	logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, tr, mt;
	logic [7:0]  adr = 8'h00, v;
	logic [3:0]  sel = 4'h0, sel_w = 4'h1;
	logic [31:0] wd = 32'h0, rdat;
	logic [15:0] td = 16'h0;
	logic [15:0] q[$];
	core_bus_t   cb, req = '0;
	int          num_errors = 0, n_checks = 0, ncyc = 0;

	debug_trace_unit #(.TRACE_WIDTH(16), .TRACE_DEPTH(8)) DUT (.clk_i(clk_i), .rst_i(rst_i),
		.trace_rst_i(trst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rdat), .wb_ack_o(ack), .core_bus_i(cb),
		.trace_valid_i(tv), .trace_data_i(td), .trace_ready_o(tr), .match_o(mt));
	core_bus_model PART (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .req_i(req), .bus_o(cb));

	// ****************
	// helpers
	// ****************
	always #5 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		ncyc++;
		if (ncyc == 20000) begin
			num_errors++;
			end_of_test();
		end
	end

	task automatic end_of_test();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			num_errors++;
			$display("wrong value %s exp %h seen %h", s, e, g);
		end
	endtask

	task automatic bus(input logic [5:0] i, input logic w, input logic [7:0] d);
		@(posedge clk_i);
		{cyc, stb, we, sel, adr, wd} <= {2'b11, w, sel_w, i, 2'b00, 24'h0, d};
		do @(posedge clk_i); while (ack !== 1'b1);
		v = rdat[7:0];
		{cyc, stb} <= 2'b00;
	endtask

	task automatic rd_chk(input string s, input logic [5:0] i, input logic [7:0] e);
		bus(i, 1'b0, 8'h00);
		chk(s, {24'h0, e}, {24'h0, v});
	endtask

	task automatic offer(input int c);
		tv <= 1'b1;
		td <= 16'($urandom);
		repeat (c) begin
			@(posedge clk_i);
			if (tr === 1'b1) begin
				q.push_back(td);
				td <= 16'($urandom);
			end
		end
		tv <= 1'b0;
	endtask

	task automatic drain(input logic ev);
		while (q.size() > 0) begin
			rd_chk("high", IDX_TRACE_HIGH, ev ? 8'h00 : q[0][15:8]);
			rd_chk("low", IDX_TRACE_LOW, q[0][7:0]);
			void'(q.pop_front());
		end
	endtask

	task automatic pulse();
		@(posedge clk_i);
		trst <= 1'b1;
		@(posedge clk_i);
		trst <= 1'b0;
	endtask

	function automatic logic em(logic [7:0] x, logic [15:0] t, core_bus_t b);
		logic [16:0] a;
		a = b.ppage_sel ? {b.ppage, b.addr[13:0]} : b.lin_sel ? b.lin_addr : {1'b0, b.addr};
		return a == {x[0], t} && b.ppage_sel == x[5] && (!x[7] || b.rd == x[6]);
	endfunction

	task automatic trial();
		logic [63:0] r;
		logic [7:0]  x;
		core_bus_t   b;
		r = {$urandom, $urandom};
		x = r[47:40] & 8'hE1;
		b = r[39:0];
		b.valid = 1'b1;
		if ($urandom % 4 != 0) b.ppage_sel = x[5];
		b.ppage = {x[0], r[63:62]};
		b.addr = r[63:48];
		b.lin_addr = {x[0], r[63:48]};
		if ($urandom % 4 == 0) b.addr[0] = ~b.addr[0];
		bus(IDX_CMP_A_HIGH, 1'b1, r[63:56]);
		bus(IDX_CMP_A_LOW, 1'b1, r[55:48]);
		bus(IDX_CMP_A_EXT, 1'b1, x);
		req <= b;
		go <= 1'b1;
		@(posedge clk_i);
		go <= 1'b0;
		repeat (2) @(posedge clk_i);
		chk("match", {31'h0, em(x, r[63:48], b)}, {31'h0, mt});
	endtask

	// ****************
	// tests
	// ****************
	initial begin
		void'($urandom(32'h699CA7AC));
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		rd_chk("low", IDX_TRACE_LOW, 8'h00);
		rd_chk("ext", IDX_CMP_A_EXT, 8'h00);
		rd_chk("unmapped", 6'h3F, 8'h00);
		bus(IDX_CMP_A_EXT, 1'b1, 8'hFF);
		rd_chk("ext", IDX_CMP_A_EXT, 8'hE1);
		sel_w = 4'h0;
		bus(IDX_CMP_A_EXT, 1'b1, 8'h00);
		sel_w = 4'h1;
		rd_chk("sel", IDX_CMP_A_EXT, 8'hE1);
		$display("test reset done");
		bus(IDX_TRACE_CTRL, 1'b1, 8'h02);
		offer(3);
		bus(IDX_TRACE_LOW, 1'b1, 8'hAA);
		rd_chk("count", IDX_TRACE_STATUS, 8'(q.size()));
		drain(1'b0);
		rd_chk("empty", IDX_TRACE_LOW, 8'h00);
		rd_chk("high empty", IDX_TRACE_HIGH, 8'h00);
		offer(20);
		chk("fill", 32'h8, q.size());
		rd_chk("full", IDX_TRACE_STATUS, 8'h08);
		drain(1'b0);
		bus(IDX_TRACE_CTRL, 1'b1, 8'h03);
		offer(4);
		drain(1'b1);
		$display("test trace done");
		repeat (40) trial();
		$display("test compare done");
		bus(IDX_TRACE_CTRL, 1'b1, 8'h82);
		offer(2);
		bus(IDX_CMP_A_EXT, 1'b1, 8'hA1);
		pulse();
		rd_chk("kept", IDX_CMP_A_EXT, 8'hA1);
		drain(1'b0);
		bus(IDX_TRACE_CTRL, 1'b1, 8'hC2);
		offer(2);
		pulse();
		q.delete();
		rd_chk("cleared", IDX_CMP_A_EXT, 8'h00);
		rd_chk("flushed", IDX_TRACE_STATUS, 8'h00);
		$display("test retention done");
		bus(IDX_TRACE_CTRL, 1'b1, 8'h82);
		bus(IDX_CMP_A_EXT, 1'b1, 8'hA1);
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		rd_chk("por ext", IDX_CMP_A_EXT, 8'h00);
		rd_chk("por ctrl", IDX_TRACE_CTRL, 8'h00);
		$display("test power-on reset done");
		end_of_test();
	end
endmodule
`default_nettype wire
